// ---- shared/iiod_pkg.sv ----
// Shared constants and carrier types for the indirect/immediate operand decoder.
// Assumes a 16-bit instruction word and up to eight 16-bit auxiliary registers.
package iiod_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int IIOD_WORD_W = 16;
  localparam int IIOD_SEL_W = 3;
  localparam int IIOD_NUM_AR = 8;
  localparam int IIOD_PAGE_W = 9;
  localparam int IIOD_MULT_W = 13;
  localparam int IIOD_BYTE_W = 8;
  localparam int IIOD_SHIFT_W = 4;
  localparam int IIOD_LONG_W = 32;
  localparam int IIOD_CM_W = 2;

  // ----------------------------------------
  // Indirect control, opcode and shift field positions
  // ----------------------------------------
  localparam int IIOD_MODE_BIT = 7;
  localparam int IIOD_INDEX_STEP_BIT = 6;
  localparam int IIOD_STEP_UP_BIT = 5;
  localparam int IIOD_STEP_DOWN_BIT = 4;
  localparam int IIOD_PTR_LOAD_BIT = 3;
  localparam int IIOD_SHIFT_LSB = 8;
  localparam int IIOD_OPC_LSB = 8;

  // ----------------------------------------
  // Fixed encodings
  // ----------------------------------------
  localparam logic [7:0] IIOD_REPEAT_OPC = 8'hCB;
  localparam logic [3:0] IIOD_ADD_LONG_HI = 4'hD;
  localparam logic [7:0] IIOD_ADD_LONG_LO = 8'h02;
  localparam logic [15:0] IIOD_STEP_ONE = 16'h0001;
  localparam logic [15:0] IIOD_ZERO16 = 16'h0000;
  localparam logic [7:0] IIOD_ZERO8 = 8'h00;
  localparam logic [2:0] IIOD_SEL_RESET = 3'h0;
  localparam logic [2:0] IIOD_INDEX_SEL = 3'h0;

  // Compare modes held in the low two bits of the compare instruction
  localparam logic [1:0] IIOD_CM_EQ = 2'h0;
  localparam logic [1:0] IIOD_CM_LT = 2'h1;
  localparam logic [1:0] IIOD_CM_GT = 2'h2;

  // Instruction class supplied by the main opcode decoder
  typedef enum logic [2:0] {
    IIOD_K_NONE = 3'b000,
    IIOD_K_MEM = 3'b001,
    IIOD_K_COMPARE_AUX_WITH_INDEX = 3'b010,
    IIOD_K_LOAD_SELECTOR_IMMEDIATE = 3'b011,
    IIOD_K_LOAD_PAGE_IMMEDIATE = 3'b100,
    IIOD_K_MULTIPLY_IMMEDIATE = 3'b101,
    IIOD_K_SHORT8 = 3'b110,
    IIOD_K_LONG = 3'b111
  } iiod_kind_t;

  typedef enum logic [0:0] {
    IIOD_S_OPCODE = 1'b0,
    IIOD_S_OPERAND = 1'b1
  } iiod_state_t;

  typedef struct packed {
    logic valid;
    iiod_kind_t kind;
    logic long_signed;
    logic [IIOD_WORD_W-1:0] word;
  } iiod_instr_t;

  typedef struct packed {
    logic [IIOD_BYTE_W-1:0] short8;
    logic [IIOD_SEL_W-1:0] sel3;
    logic [IIOD_PAGE_W-1:0] page9;
    logic [IIOD_WORD_W-1:0] mult16;
    logic [IIOD_BYTE_W-1:0] repeat_count;
  } iiod_short_t;

  typedef struct packed {
    logic valid;
    logic add_long;
    logic [IIOD_LONG_W-1:0] value;
  } iiod_long_t;

endpackage

// ---- hdl/iiod_decode.sv ----
// Indirect-addressing control decode, auxiliary register file and
// immediate operand extraction for a 16-bit DSP core.
// Assumes the opcode decoder presents one word per instr.valid pulse and
// classifies it; repeat and add-long-immediate are recognised here by bits.
// How it works
// - Step bit clear: current register moves by one or stays.
// - Step bit set: index register added or subtracted per bits 5 and 4.
// - Bit 5 requests increment, bit 4 requests decrement.
// - Step clear: 00 hold, 01 minus one, 10 plus one, 11 hold.
// - 100 and 111 use reverse carry; 101 and 110 use normal carry.
// - Pointer-load bit set loads bits 2..0 into the selector.
// - Pointer-load bit clear keeps the selector.
// - Bit 7 set selects indirect; opcode 15..8, control field 6..0.
// - Address is the pre-update register; update follows in same cycle.
// - Compare current register with index register into the test flag.
// - Short immediates come from the word: 3, 8, 9 or 13 bit constants.
// - Short immediate results appear one cycle after the word.
// - Selector load 3 bits, page load 9 bits, multiply 13-bit signed.
// - Repeat immediate runs the next instruction count plus one times.
// - Long immediate takes the following word as its operand.
// - Long constant is zero or sign extended as selected.
// - Add-long: 1101 in 15..12, shift in 11..8, constant next word.
`timescale 1ns/1ps

module iiod_decode #(
  parameter int NUM_AR = iiod_pkg::IIOD_NUM_AR
) (
  input wire logic clk,
  input wire logic resetn,
  input wire iiod_pkg::iiod_instr_t instr,
  input wire logic ar_wr_en,
  input wire logic [iiod_pkg::IIOD_SEL_W-1:0] ar_wr_sel,
  input wire logic [iiod_pkg::IIOD_WORD_W-1:0] ar_wr_data,
  output logic [iiod_pkg::IIOD_WORD_W-1:0] data_addr,
  output logic data_addr_valid,
  output logic [iiod_pkg::IIOD_SEL_W-1:0] aux_reg_selector,
  output logic [iiod_pkg::IIOD_WORD_W-1:0] current_aux_register,
  output logic test_flag,
  output iiod_pkg::iiod_short_t short_imm,
  output logic short_imm_valid,
  output iiod_pkg::iiod_long_t long_imm,
  output logic repeat_hold,
  output logic operand_wait
);
  import iiod_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [IIOD_WORD_W-1:0] bit_rev(input logic [IIOD_WORD_W-1:0] v);
    logic [IIOD_WORD_W-1:0] r;
    r = IIOD_ZERO16;
    for (int i = 0; i < IIOD_WORD_W; i++) begin
      r[i] = v[IIOD_WORD_W-1-i];
    end
    return r;
  endfunction

  // Reverse carry is done by mirroring both operands and the result; costs three wire swaps
  function automatic logic [IIOD_WORD_W-1:0] rc_sum(input logic [IIOD_WORD_W-1:0] a,
                                                    input logic [IIOD_WORD_W-1:0] b,
                                                    input logic sub);
    logic [IIOD_WORD_W-1:0] ra;
    logic [IIOD_WORD_W-1:0] rb;
    ra = bit_rev(a);
    rb = bit_rev(b);
    return sub ? bit_rev(ra - rb) : bit_rev(ra + rb);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [IIOD_WORD_W-1:0] ar_reg [NUM_AR];
  logic [IIOD_SEL_W-1:0] sel_reg;
  logic flag_reg;
  iiod_state_t state_reg;
  logic signed_reg;
  logic add_long_reg;
  logic [IIOD_SHIFT_W-1:0] shift_reg;
  logic [IIOD_BYTE_W-1:0] rpt_reg;
  logic rpt_armed_reg;
  logic [IIOD_WORD_W-1:0] addr_reg;
  logic addr_valid_reg;
  iiod_short_t short_reg;
  logic short_valid_reg;
  iiod_long_t long_reg;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic [IIOD_WORD_W-1:0] w = instr.word;
  wire logic take_op = instr.valid && (state_reg == IIOD_S_OPCODE);
  wire logic take_operand = instr.valid && (state_reg == IIOD_S_OPERAND);
  wire logic is_add_long = (w[IIOD_WORD_W-1:IIOD_SHIFT_LSB+IIOD_SHIFT_W] == IIOD_ADD_LONG_HI)
                           && (w[IIOD_BYTE_W-1:0] == IIOD_ADD_LONG_LO);
  wire logic is_repeat = (w[15:IIOD_OPC_LSB] == IIOD_REPEAT_OPC);
  wire logic is_long = (instr.kind == IIOD_K_LONG) || is_add_long;
  wire logic is_short = (instr.kind == IIOD_K_LOAD_SELECTOR_IMMEDIATE) || (instr.kind == IIOD_K_LOAD_PAGE_IMMEDIATE)
                        || (instr.kind == IIOD_K_MULTIPLY_IMMEDIATE) || (instr.kind == IIOD_K_SHORT8)
                        || is_repeat;
  wire logic is_indirect = take_op && (instr.kind == IIOD_K_MEM)
                           && w[IIOD_MODE_BIT];
  wire logic idx_step = w[IIOD_INDEX_STEP_BIT];
  wire logic step_up = w[IIOD_STEP_UP_BIT];
  wire logic step_dn = w[IIOD_STEP_DOWN_BIT];
  wire logic ptr_load = w[IIOD_PTR_LOAD_BIT];
  wire logic [IIOD_SEL_W-1:0] next_sel = w[IIOD_SEL_W-1:0];

  wire logic [IIOD_WORD_W-1:0] cur_ar = ar_reg[sel_reg];
  wire logic [IIOD_WORD_W-1:0] idx_ar = ar_reg[IIOD_INDEX_SEL];
  // Step amount: one or the index register
  wire logic [IIOD_WORD_W-1:0] step_amt = idx_step ? idx_ar : IIOD_STEP_ONE;
  // Reverse carry on 100 and 111 only
  wire logic use_rc = idx_step && (step_up == step_dn);
  wire logic rc_sub = !step_up;
  wire logic plain_up = step_up && !step_dn;
  wire logic plain_dn = step_dn && !step_up;
  logic [IIOD_WORD_W-1:0] ar_next;
  always_comb begin
    if (use_rc) begin
      ar_next = rc_sum(cur_ar, step_amt, rc_sub);
    end else if (plain_up) begin
      ar_next = cur_ar + step_amt;
    end else if (plain_dn) begin
      ar_next = cur_ar - step_amt;
    end else begin
      ar_next = cur_ar;
    end
  end

  // Compare mode 11 means not equal
  wire logic [IIOD_CM_W-1:0] cm = w[IIOD_CM_W-1:0];
  wire logic cmp_result = (cm == IIOD_CM_EQ) ? (cur_ar == idx_ar) :
                          (cm == IIOD_CM_LT) ? (cur_ar < idx_ar) :
                          (cm == IIOD_CM_GT) ? (cur_ar > idx_ar) :
                          (cur_ar != idx_ar);

  wire logic [IIOD_LONG_W-1:0] ext_const = take_operand && signed_reg ?
    {{(IIOD_LONG_W-IIOD_WORD_W){w[IIOD_WORD_W-1]}}, w} :
    {{(IIOD_LONG_W-IIOD_WORD_W){1'b0}}, w};
  wire logic [IIOD_LONG_W-1:0] shifted = ext_const << shift_reg;

  wire iiod_short_t short_next = '{
    short8: w[IIOD_BYTE_W-1:0],
    sel3: w[IIOD_SEL_W-1:0],
    page9: w[IIOD_PAGE_W-1:0],
    mult16: {{(IIOD_WORD_W-IIOD_MULT_W){w[IIOD_MULT_W-1]}}, w[IIOD_MULT_W-1:0]},
    repeat_count: w[IIOD_BYTE_W-1:0]
  };

  // Repeat: one extra execution is pending per count, so count+1 in total
  wire logic rpt_busy = rpt_armed_reg && (rpt_reg != IIOD_ZERO8);
  wire logic rpt_start = take_op && is_short && is_repeat;

  // ----------------------------------------
  // Auxiliary register file
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_AR; i++) begin
        ar_reg[i] <= IIOD_ZERO16;
      end
    end else begin
      if (ar_wr_en) begin
        ar_reg[ar_wr_sel] <= ar_wr_data;
      end
      if (is_indirect) begin
        ar_reg[sel_reg] <= ar_next;
      end
    end
  end

  // ----------------------------------------
  // Selector, flag, addressing
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sel_reg <= IIOD_SEL_RESET;
      flag_reg <= 1'b0;
      addr_reg <= IIOD_ZERO16;
      addr_valid_reg <= 1'b0;
    end else begin
      addr_valid_reg <= is_indirect;
      if (is_indirect) begin
        addr_reg <= cur_ar;
      end
      if (is_indirect && ptr_load) begin
        sel_reg <= next_sel;
      end else if (take_op && instr.kind == IIOD_K_LOAD_SELECTOR_IMMEDIATE) begin
        sel_reg <= next_sel;
      end
      if (take_op && instr.kind == IIOD_K_COMPARE_AUX_WITH_INDEX) begin
        flag_reg <= cmp_result;
      end
    end
  end

  // ----------------------------------------
  // Immediate operands
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= IIOD_S_OPCODE;
      signed_reg <= 1'b0;
      add_long_reg <= 1'b0;
      shift_reg <= '0;
      short_reg <= '0;
      short_valid_reg <= 1'b0;
      long_reg <= '0;
    end else begin
      short_valid_reg <= take_op && is_short;
      if (take_op && is_short) begin
        short_reg <= short_next;
      end
      long_reg.valid <= take_operand;
      if (take_operand) begin
        long_reg.value <= shifted;
        long_reg.add_long <= add_long_reg;
      end
      case (state_reg)
        IIOD_S_OPCODE: begin
          if (take_op && is_long) begin
            state_reg <= IIOD_S_OPERAND;
            signed_reg <= instr.long_signed;
            add_long_reg <= is_add_long;
            shift_reg <= w[IIOD_SHIFT_LSB+IIOD_SHIFT_W-1:IIOD_SHIFT_LSB];
          end
        end
        IIOD_S_OPERAND: begin
          if (take_operand) begin
            state_reg <= IIOD_S_OPCODE;
          end
        end
        default: begin
          state_reg <= IIOD_S_OPCODE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Repeat counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rpt_reg <= IIOD_ZERO8;
      rpt_armed_reg <= 1'b0;
    end else if (rpt_start) begin
      rpt_reg <= w[IIOD_BYTE_W-1:0];
      rpt_armed_reg <= 1'b1;
    end else if (instr.valid && rpt_armed_reg) begin
      // Each accepted word of the repeated instruction burns one count; the word accepted at zero disarms instead
      if (rpt_busy) begin
        rpt_reg <= rpt_reg - 8'h01;
      end else begin
        rpt_armed_reg <= 1'b0;
      end
    end
  end

  assign data_addr = addr_reg;
  assign data_addr_valid = addr_valid_reg;
  assign aux_reg_selector = sel_reg;
  assign current_aux_register = cur_ar;
  assign test_flag = flag_reg;
  assign short_imm = short_reg;
  assign short_imm_valid = short_valid_reg;
  assign long_imm = long_reg;
  assign repeat_hold = rpt_busy;
  assign operand_wait = (state_reg == IIOD_S_OPERAND);

endmodule

// ---- testbench/iiod_decode_assertions.sv ----
// Port-level checker for the operand decoder.
// Assumes it is bound onto every iiod_decode instance.
`timescale 1ns/1ps
module iiod_decode_assertions #(
  parameter int NUM_AR = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire iiod_pkg::iiod_instr_t instr,
  input wire logic ar_wr_en,
  input wire logic [2:0] ar_wr_sel,
  input wire logic [15:0] ar_wr_data,
  input wire logic [15:0] data_addr,
  input wire logic data_addr_valid,
  input wire logic [2:0] aux_reg_selector,
  input wire logic [15:0] current_aux_register,
  input wire logic test_flag,
  input wire iiod_pkg::iiod_short_t short_imm,
  input wire logic short_imm_valid,
  input wire iiod_pkg::iiod_long_t long_imm,
  input wire logic repeat_hold,
  input wire logic operand_wait
);
  import iiod_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // -------- Decode --------
  logic ind;
  logic lop;
  assign ind = instr.valid && !operand_wait && instr.kind == IIOD_K_MEM && instr.word[7];
  assign lop = instr.valid && !operand_wait && (instr.kind == IIOD_K_LONG ||
    (instr.word[15:12] == IIOD_ADD_LONG_HI && instr.word[7:0] == IIOD_ADD_LONG_LO));
  // -------- Properties --------
  // Side load excluded so only the step logic moves the register
  sequence s_ind(p);
    ind && instr.word[6:4] == p && !instr.word[3] && !ar_wr_en;
  endsequence
  property p_ptr_keep;
    ind && !instr.word[3] |=> $stable(aux_reg_selector);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("selector moved");
  property p_ptr_load;
    ind && instr.word[3] |=> aux_reg_selector == $past(instr.word[2:0]);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("selector not loaded");
  property p_addr;
    ind |=> data_addr_valid && data_addr == $past(current_aux_register);
  endproperty
  a_addr: assert property (p_addr) else $error("address not pre-update");
  property p_inc;
    s_ind(3'b010) |=> current_aux_register == $past(current_aux_register) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("step up wrong");
  property p_dec;
    s_ind(3'b001) |=> current_aux_register == $past(current_aux_register) - 16'h0001;
  endproperty
  a_dec: assert property (p_dec) else $error("step down wrong");
  property p_hold;
    ind && !instr.word[6] && instr.word[5] == instr.word[4] && !instr.word[3] && !ar_wr_en
      |=> $stable(current_aux_register);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed");
  property p_idx;
    (s_ind(3'b110) ##0 (aux_reg_selector == IIOD_INDEX_SEL)) |=>
      current_aux_register == $past(current_aux_register) + $past(current_aux_register);
  endproperty
  a_idx: assert property (p_idx) else $error("index add wrong");
  property p_short;
    instr.valid && !operand_wait && instr.kind == IIOD_K_MULTIPLY_IMMEDIATE |=> short_imm_valid &&
      short_imm.mult16 == {{3{$past(instr.word[12])}}, $past(instr.word[12:0])};
  endproperty
  a_short: assert property (p_short) else $error("multiply constant wrong");
  property p_long_start;
    lop |=> operand_wait && !long_imm.valid;
  endproperty
  a_long_start: assert property (p_long_start) else $error("no operand wait");
  property p_long_done;
    operand_wait && instr.valid |=> long_imm.valid && !operand_wait;
  endproperty
  a_long_done: assert property (p_long_done) else $error("long value missing");
endmodule

bind iiod_decode iiod_decode_assertions #(.NUM_AR(NUM_AR)) chk_i (.clk, .resetn, .instr,
  .ar_wr_en, .ar_wr_sel, .ar_wr_data, .data_addr, .data_addr_valid, .aux_reg_selector,
  .current_aux_register, .test_flag, .short_imm, .short_imm_valid, .long_imm,
  .repeat_hold, .operand_wait);

// ---- testbench/iiod_fetch_model.sv ----
// Fetch-side model presenting instruction words to the decoder.
// Assumes one caller at a time through the issue task.
`timescale 1ns/1ps
module iiod_fetch_model (
  input wire logic clk,
  input wire logic repeat_hold,
  output iiod_pkg::iiod_instr_t instr
);
  import iiod_pkg::*;
  initial instr = '0;
  // Word kept while repeats remain; n counts executions
  task automatic issue(input iiod_kind_t k, input logic s, input logic [15:0] w, output int n);
    logic h;
    n = 0;
    @(posedge clk);
    instr <= '{1'b1, k, s, w};
    repeat (300) begin
      @(negedge clk);
      h = repeat_hold;
      @(posedge clk);
      n++;
      if (!h) break;
    end
    // Released word shows a changed pattern, never the last one
    instr <= '{1'b0, IIOD_K_NONE, 1'b0, ~w};
  endtask
endmodule

// ---- testbench/iiod_decode_tb_top.sv ----
// Self-checking bench for the operand decoder.
// Assumes the fetch model and the bound checker beside it.
`timescale 1ns/1ps
module iiod_decode_tb_top;
  import iiod_pkg::*;
  logic clk, resetn, ar_wr_en, data_addr_valid, test_flag, short_imm_valid;
  logic repeat_hold, operand_wait;
  logic [2:0] ar_wr_sel, aux_reg_selector;
  logic [15:0] ar_wr_data, data_addr, current_aux_register;
  iiod_instr_t instr;
  iiod_short_t short_imm;
  iiod_long_t long_imm;
  int n, n_mismatch, cmp_count;
  // Entries: word, expected address, selector, register after
  logic [51:0] tab [13] = '{52'h0889_0008_1_0000, 52'h08F0_0000_1_0008,
    52'h08F0_0008_1_0004, 52'h08C0_0004_1_0008, 52'h08E0_0008_1_0010,
    52'h08D0_0010_1_0008, 52'h08A0_0008_1_0009, 52'h0890_0009_1_0008,
    52'h08B0_0008_1_0008, 52'h08BA_0008_2_0000, 52'h0890_0000_2_FFFF,
    52'h08F8_FFFF_0_0008, 52'h08E0_0008_0_0010};
  iiod_decode uut (.clk(clk), .resetn(resetn), .instr(instr), .ar_wr_en(ar_wr_en),
    .ar_wr_sel(ar_wr_sel), .ar_wr_data(ar_wr_data), .data_addr(data_addr),
    .data_addr_valid(data_addr_valid), .aux_reg_selector(aux_reg_selector),
    .current_aux_register(current_aux_register), .test_flag(test_flag),
    .short_imm(short_imm), .short_imm_valid(short_imm_valid), .long_imm(long_imm),
    .repeat_hold(repeat_hold), .operand_wait(operand_wait));
  iiod_fetch_model fetch (.clk(clk), .repeat_hold(repeat_hold), .instr(instr));
  // -------- Tasks --------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic go(input iiod_kind_t k, input logic s, input logic [15:0] w);
    fetch.issue(k, s, w, n);
    #1;
    // Fetch loop used up its bound: repeat hold never dropped
    if (n >= 300) begin
      n_mismatch++;
      $display("MISMATCH t=%0t repeat hold never released", $time);
      conclude();
    end
  endtask
  task automatic ar_wr(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk);
    ar_wr_en <= 1'b1;
    ar_wr_sel <= s;
    ar_wr_data <= d;
    @(posedge clk);
    ar_wr_en <= 1'b0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // -------- Sequence --------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    ar_wr_en = 1'b0;
    ar_wr_sel = 3'h0;
    ar_wr_data = 16'h0000;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk({repeat_hold, operand_wait, test_flag, aux_reg_selector, current_aux_register}, 0);
    ar_wr(3'h0, 16'h0008);
    ar_wr(3'h1, 16'h0000);
    for (int i = 0; i < 13; i++) begin
      go(IIOD_K_MEM, 1'b0, tab[i][51:36]);
      chk({data_addr_valid, data_addr}, {1'b1, tab[i][35:20]});
      chk({1'b0, aux_reg_selector, current_aux_register}, tab[i][19:0]);
    end
    go(IIOD_K_MEM, 1'b0, 16'h0809);
    chk({data_addr_valid, current_aux_register}, {1'b0, 16'h0010});
    go(IIOD_K_SHORT8, 1'b0, 16'hCB05);
    chk({short_imm_valid, short_imm.repeat_count}, {1'b1, 8'h05});
    chk(short_imm.short8, 8'h05);
    go(IIOD_K_MEM, 1'b0, 16'h08A0);
    chk({n[7:0], current_aux_register}, {8'h06, 16'h0016});
    go(IIOD_K_LOAD_PAGE_IMMEDIATE, 1'b0, 16'hFFFF);
    chk({short_imm_valid, short_imm.page9}, {1'b1, 9'h1FF});
    go(IIOD_K_MULTIPLY_IMMEDIATE, 1'b0, 16'h3000);
    chk({short_imm_valid, short_imm.mult16}, {1'b1, 16'hF000});
    go(IIOD_K_LOAD_SELECTOR_IMMEDIATE, 1'b0, 16'h00FD);
    chk({aux_reg_selector, short_imm.sel3}, {3'h5, 3'h5});
    for (int j = 0; j < 2; j++) begin
      ar_wr(3'h5, j ? 16'h0016 : 16'h0005);
      for (int m = 0; m < 4; m++) begin
        go(IIOD_K_COMPARE_AUX_WITH_INDEX, 1'b0, 16'hCE50 + 16'(m));
        chk(test_flag, j ? (m == 0) : m[0]);
      end
    end
    go(IIOD_K_LONG, 1'b0, 16'hD202);
    chk(operand_wait, 1'b1);
    go(IIOD_K_NONE, 1'b0, 16'h4000);
    chk({long_imm.valid, long_imm.add_long, long_imm.value}, {2'b11, 32'h00010000});
    go(IIOD_K_LONG, 1'b1, 16'hB300);
    go(IIOD_K_NONE, 1'b1, 16'h8000);
    chk({long_imm.valid, long_imm.add_long, long_imm.value}, {2'b10, 32'hFFFC0000});
    conclude();
  end
endmodule
